// >>> urf_pkg.sv
// constants and state encoding for the receiver front end
package urf_pkg;

    localparam int OVERSAMPLE = 16;
    localparam int START_LOW_MIN = 7;
    localparam int HALF_BIT = 8;
    localparam int FIRST_SAMPLE = 24;
    localparam int DATA_BITS = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_STAGES = 2;
    localparam int PHASE_W = 5;

    localparam logic [PHASE_W-1:0] PH_ZERO = 5'h00;
    localparam logic [PHASE_W-1:0] PH_ONE = 5'h01;
    localparam logic [PHASE_W-1:0] PH_ACCEPT = 5'h07;
    localparam logic [PHASE_W-1:0] PH_SAMPLE = 5'h18;
    localparam logic [PHASE_W-1:0] PH_RELOAD = 5'h08;

    typedef enum logic [2:0] {
        URF_OFF = 3'h0,
        URF_HUNT = 3'h1,
        URF_START = 3'h3,
        URF_DATA = 3'h2,
        URF_STOP = 3'h6
    } urf_state_t;

endpackage : urf_pkg

// >>> urf_stream_if.sv
// valid/ready stream carrier between the receiver and its buffer
`timescale 1ns/1ps
interface urf_stream_if #(
    parameter int WIDTH = 8
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (
        output valid,
        output data,
        input ready
    );

    modport snk (
        input valid,
        input data,
        output ready
    );
endinterface : urf_stream_if

// >>> urf_sync.sv
// multi-stage synchroniser for the serial input pin
`timescale 1ns/1ps
module urf_sync #(
    parameter int STAGES = urf_pkg::SYNC_STAGES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic async_in,
    output logic sync_out
);
    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;

    if (STAGES < 2) begin : g_bad_stages
        $error("urf_sync needs at least two stages");
    end

    // idle line is high, so the chain resets to ones
    always_comb begin
        next_chain = {chain[STAGES-2:0], async_in};
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            chain <= '1;
        end else begin
            chain <= next_chain;
        end
    end

    assign sync_out = chain[STAGES-1];

    property p_sync_delay;
        @(posedge clk_sys) disable iff (!rstn)
        rstn && $past(rstn) && $past(rstn, 2) |->
            sync_out == $past(async_in, STAGES);
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("synchroniser latency wrong");
endmodule // urf_sync

// >>> urf_fifo.sv
// small synchronous fifo between receiver and consumer
`timescale 1ns/1ps
module urf_fifo #(
    parameter int WIDTH = urf_pkg::DATA_BITS,
    parameter int DEPTH = urf_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rstn,
    urf_stream_if.snk wr,
    urf_stream_if.src rd
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic do_wr;
    logic do_rd;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("urf_fifo depth must be a power of two, at least 2");
    end

    assign wr.ready = (count != FULL_CNT);
    assign rd.valid = (count != '0);
    assign rd.data = mem[rd_ptr];

    always_comb begin
        do_wr = wr.valid && wr.ready;
        do_rd = rd.valid && rd.ready;
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (do_wr && !do_rd) begin
            next_count = count + 1'b1;
        end else if (do_rd && !do_wr) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage needs no reset; count guards every read
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr.data;
        end
    end
endmodule // urf_fifo

// >>> urf_rx.sv
// receiver front end: commands, start detection, mid-bit sampling
`timescale 1ns/1ps
// Operation
// - after reset the receiver is disabled and ignores the line.
// - an enable command starts the hunt for a start bit.
// - a disable while waiting for a start bit stops at once.
// - a disable during a character waits until its stop bit.
// - a reset command aborts at once, disables and drops the character.
// - a start bit needs the line low for more than seven ticks.
// - a low of seven ticks or fewer is ignored and hunting goes on.
// - each bit is sixteen ticks long and sampled at its centre.
// - the first data sample falls 24 ticks after the falling edge.
// - each later sample falls 16 ticks after the one before.
// - timing comes only from the local 16x tick, never a line clock.
module urf_rx #(
    parameter int DATA_BITS = urf_pkg::DATA_BITS,
    parameter int FIFO_DEPTH = urf_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic sample_tick,
    input wire logic serial_receive_line,
    input wire logic receive_enable_cmd,
    input wire logic receive_disable_cmd,
    input wire logic receiver_reset_cmd,
    input wire logic rx_ready,
    output logic [DATA_BITS-1:0] rx_data,
    output logic rx_valid,
    output logic rx_overrun,
    output logic rx_enabled,
    output logic rx_busy
);
    localparam int BW = $clog2(DATA_BITS + 1);
    localparam logic [BW-1:0] LAST_BIT = BW'(DATA_BITS - 1);

    if (DATA_BITS < 5 || DATA_BITS > 9) begin : g_bad_bits
        $error("urf_rx supports 5 to 9 data bits");
    end

    urf_pkg::urf_state_t state;
    urf_pkg::urf_state_t next_state;
    logic [urf_pkg::PHASE_W-1:0] phase;
    logic [urf_pkg::PHASE_W-1:0] next_phase;
    logic [BW-1:0] bit_idx;
    logic [BW-1:0] next_bit_idx;
    logic [DATA_BITS-1:0] shreg;
    logic [DATA_BITS-1:0] next_shreg;
    logic dis_pend;
    logic next_dis_pend;
    logic push_v;
    logic next_push_v;
    logic [DATA_BITS-1:0] push_d;
    logic [DATA_BITS-1:0] next_push_d;
    logic next_overrun;
    logic next_rx_valid;
    logic [DATA_BITS-1:0] next_rx_data;
    logic line_s;
    logic sample_now;

    urf_stream_if #(.WIDTH(DATA_BITS)) wr_if ();
    urf_stream_if #(.WIDTH(DATA_BITS)) rd_if ();

    // pin crosses into clk_sys before start detection
    urf_sync #(
        .STAGES(urf_pkg::SYNC_STAGES)
    ) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .async_in(serial_receive_line),
        .sync_out(line_s)
    );

    urf_fifo #(
        .WIDTH(DATA_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .wr(wr_if.snk),
        .rd(rd_if.src)
    );

    assign wr_if.valid = push_v;
    assign wr_if.data = push_d;
    // output stage refills whenever empty or being drained
    assign rd_if.ready = !rx_valid || rx_ready;

    // bit timing runs purely off the local oversampling tick
    assign sample_now = sample_tick && (state == urf_pkg::URF_DATA ||
        state == urf_pkg::URF_STOP) &&
        (phase == urf_pkg::PH_SAMPLE - 1'b1);

    always_comb begin
        next_state = state;
        next_phase = phase;
        next_bit_idx = bit_idx;
        next_shreg = shreg;
        next_dis_pend = dis_pend;
        next_push_v = 1'b0;
        next_push_d = push_d;
        case (state)
            urf_pkg::URF_OFF: begin
                if (receive_enable_cmd && !receive_disable_cmd) begin
                    next_state = urf_pkg::URF_HUNT;
                end
            end
            urf_pkg::URF_HUNT: begin
                // first low tick marks the falling edge
                if (sample_tick && !line_s) begin
                    next_state = urf_pkg::URF_START;
                    next_phase = urf_pkg::PH_ZERO;
                end
            end
            urf_pkg::URF_START: begin
                if (sample_tick) begin
                    if (line_s) begin
                        next_state = urf_pkg::URF_HUNT;
                    end else begin
                        next_phase = phase + urf_pkg::PH_ONE;
                        if (next_phase == urf_pkg::PH_ACCEPT) begin
                            next_state = urf_pkg::URF_DATA;
                            next_bit_idx = '0;
                        end
                    end
                end
            end
            urf_pkg::URF_DATA: begin
                if (sample_tick) begin
                    next_phase = phase + urf_pkg::PH_ONE;
                end
                if (sample_now) begin
                    // phase restarts at the half-bit point of the bit just sampled
                    next_phase = urf_pkg::PH_RELOAD;
                    next_shreg = {line_s, shreg[DATA_BITS-1:1]};
                    next_bit_idx = bit_idx + 1'b1;
                    if (bit_idx == LAST_BIT) begin
                        next_state = urf_pkg::URF_STOP;
                    end
                end
            end
            urf_pkg::URF_STOP: begin
                if (sample_tick) begin
                    next_phase = phase + urf_pkg::PH_ONE;
                end
                if (sample_now) begin
                    // stop level is not judged here, the character is kept
                    next_push_v = 1'b1;
                    next_push_d = shreg;
                    next_phase = urf_pkg::PH_ZERO;
                    next_dis_pend = 1'b0;
                    next_state = dis_pend ? urf_pkg::URF_OFF
                        : urf_pkg::URF_HUNT;
                end
            end
            default: begin
                next_state = urf_pkg::URF_OFF;
            end
        endcase
        if (receive_disable_cmd) begin
            if (state == urf_pkg::URF_HUNT || state == urf_pkg::URF_START) begin
                next_state = urf_pkg::URF_OFF;
            end else if (state == urf_pkg::URF_DATA ||
                (state == urf_pkg::URF_STOP && !sample_now)) begin
                next_dis_pend = 1'b1;
            end else if (sample_now) begin
                // disable on the stop sample itself still stops afterwards
                next_state = urf_pkg::URF_OFF;
            end
        end else if (receive_enable_cmd) begin
            next_dis_pend = 1'b0;
        end
        // reset outranks every other command and drops the character
        if (receiver_reset_cmd) begin
            next_state = urf_pkg::URF_OFF;
            next_dis_pend = 1'b0;
            next_push_v = 1'b0;
            next_phase = urf_pkg::PH_ZERO;
            next_bit_idx = '0;
        end
    end

    // overrun: a finished character met a full buffer; set beats clear
    always_comb begin
        next_overrun = rx_overrun;
        if (receiver_reset_cmd) begin
            next_overrun = 1'b0;
        end
        if (push_v && !wr_if.ready) begin
            next_overrun = 1'b1;
        end
        next_rx_valid = rx_valid;
        next_rx_data = rx_data;
        if (rd_if.valid && rd_if.ready) begin
            next_rx_valid = 1'b1;
            next_rx_data = rd_if.data;
        end else if (rx_ready) begin
            next_rx_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= urf_pkg::URF_OFF;
            phase <= urf_pkg::PH_ZERO;
            bit_idx <= '0;
            shreg <= '0;
            dis_pend <= 1'b0;
            push_v <= 1'b0;
            push_d <= '0;
            rx_overrun <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= '0;
            rx_enabled <= 1'b0;
            rx_busy <= 1'b0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            bit_idx <= next_bit_idx;
            shreg <= next_shreg;
            dis_pend <= next_dis_pend;
            push_v <= next_push_v;
            push_d <= next_push_d;
            rx_overrun <= next_overrun;
            rx_valid <= next_rx_valid;
            rx_data <= next_rx_data;
            rx_enabled <= (next_state != urf_pkg::URF_OFF);
            rx_busy <= (next_state == urf_pkg::URF_DATA ||
                next_state == urf_pkg::URF_STOP);
        end
    end

    // tick count since the edge or the last sample, apart from phase
    logic [4:0] chk_gap;
    logic [4:0] next_chk_gap;

    always_comb begin
        next_chk_gap = chk_gap;
        if (sample_now || state == urf_pkg::URF_HUNT) begin
            next_chk_gap = 5'h00;
        end else if (sample_tick && chk_gap != 5'h1f) begin
            next_chk_gap = chk_gap + 5'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            chk_gap <= 5'h00;
        end else begin
            chk_gap <= next_chk_gap;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    property p_reset_off;
        $rose(rstn) |-> state == urf_pkg::URF_OFF && !rx_enabled;
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("receiver not disabled after reset");

    property p_enable;
        state == urf_pkg::URF_OFF && receive_enable_cmd &&
            !receive_disable_cmd && !receiver_reset_cmd
            |=> state == urf_pkg::URF_HUNT ##0 rx_enabled;
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable did not start hunting");

    property p_dis_idle;
        (state == urf_pkg::URF_HUNT || state == urf_pkg::URF_START) &&
            receive_disable_cmd |=> state == urf_pkg::URF_OFF;
    endproperty
    a_dis_idle: assert property (p_dis_idle)
        else $error("disable while hunting did not stop");

    property p_dis_busy;
        state == urf_pkg::URF_DATA && receive_disable_cmd &&
            !receiver_reset_cmd |=> state != urf_pkg::URF_OFF && dis_pend;
    endproperty
    a_dis_busy: assert property (p_dis_busy)
        else $error("disable cut a character short");

    property p_rst_cmd;
        receiver_reset_cmd |=> state == urf_pkg::URF_OFF && !push_v &&
            !rx_enabled;
    endproperty
    a_rst_cmd: assert property (p_rst_cmd)
        else $error("reset command did not abort");

    property p_accept;
        state == urf_pkg::URF_START && next_state == urf_pkg::URF_DATA
            |-> sample_tick && !line_s && phase == 5'h06;
    endproperty
    a_accept: assert property (p_accept)
        else $error("start accepted without eight low ticks");

    property p_glitch;
        state == urf_pkg::URF_START && sample_tick && line_s &&
            !receiver_reset_cmd && !receive_disable_cmd
            |=> state == urf_pkg::URF_HUNT;
    endproperty
    a_glitch: assert property (p_glitch)
        else $error("short low not rejected");

    property p_first_sample;
        state == urf_pkg::URF_DATA && bit_idx == '0 && sample_now
            |-> chk_gap == 5'h17;
    endproperty
    a_first_sample: assert property (p_first_sample)
        else $error("first sample not at tick 24");

    property p_later_sample;
        sample_now && (state == urf_pkg::URF_STOP || bit_idx != '0)
            |-> chk_gap == 5'h0f;
    endproperty
    a_later_sample: assert property (p_later_sample)
        else $error("later sample not 16 ticks after previous");

    property p_next_sample;
        state == urf_pkg::URF_DATA && sample_now && !receiver_reset_cmd
            |=> phase == urf_pkg::PH_RELOAD;
    endproperty
    a_next_sample: assert property (p_next_sample)
        else $error("sample spacing not 16 ticks");

    property p_phase_tick;
        (state == urf_pkg::URF_DATA || state == urf_pkg::URF_STOP) &&
            !sample_tick && !receiver_reset_cmd |=> $stable(phase);
    endproperty
    a_phase_tick: assert property (p_phase_tick)
        else $error("bit timing moved without a tick");

    c_char: cover property (state == urf_pkg::URF_STOP && sample_now);
    c_glitch: cover property (state == urf_pkg::URF_START && sample_tick
        && line_s);
    c_defer: cover property (state == urf_pkg::URF_STOP && dis_pend
        && sample_now);
    c_full: cover property (push_v && !wr_if.ready);
endmodule // urf_rx

// >>> urf_tx_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module urf_tx_model (
    input wire logic clk_sys,
    input wire logic sample_tick,
    output logic line
);
    // idle level of the line is high (mark)
    initial line = 1'b1;

    // timing counted on the 16x tick only, no clock line exists
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            while (sample_tick !== 1'b1) @(posedge clk_sys);
        end
    endtask

    // start, data lsb first, stop; sixteen ticks per bit
    task automatic send_char(input logic [7:0] d);
        ticks(1);
        line <= 1'b0;
        ticks(16);
        for (int i = 0; i < 8; i++) begin
            line <= d[i];
            ticks(16);
        end
        line <= 1'b1;
        ticks(16);
    endtask

    // short space on the line, then back to mark
    task automatic low_pulse(input int n);
        ticks(1);
        line <= 1'b0;
        ticks(n);
        line <= 1'b1;
        ticks(2);
    endtask
endmodule // urf_tx_model

// >>> urf_rx_bench.sv
// self-checking bench for the receiver front end
`timescale 1ns/1ps
module urf_rx_bench;
    logic clk_sys;
    logic rstn;
    logic sample_tick;
    logic serial_receive_line;
    logic receive_enable_cmd;
    logic receive_disable_cmd;
    logic receiver_reset_cmd;
    logic rx_ready;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_overrun;
    logic rx_enabled;
    logic rx_busy;
    logic hold_off;
    logic [7:0] exp_q[$];
    int err_count;
    int tests_run;

    urf_rx dut (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sample_tick(sample_tick),
        .serial_receive_line(serial_receive_line),
        .receive_enable_cmd(receive_enable_cmd),
        .receive_disable_cmd(receive_disable_cmd),
        .receiver_reset_cmd(receiver_reset_cmd),
        .rx_ready(rx_ready),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .rx_overrun(rx_overrun),
        .rx_enabled(rx_enabled),
        .rx_busy(rx_busy)
    );

    urf_tx_model tx (
        .clk_sys(clk_sys),
        .sample_tick(sample_tick),
        .line(serial_receive_line)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // tick every second clock, one cycle wide
    always @(negedge clk_sys) sample_tick <= ~sample_tick;

    // consumer stalls at random unless held off
    always @(negedge clk_sys) begin
        rx_ready <= hold_off ? 1'b0 : 1'($urandom_range(0, 1));
    end

    task automatic check_bit(string name, logic exp, logic got);
        tests_run++;
        if (exp !== got) begin
            err_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_byte(string name, logic [7:0] exp, logic [7:0] got);
        tests_run++;
        if (exp !== got) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // each popped word is matched to the oldest note
    always @(posedge clk_sys) begin
        if (rstn === 1'b1 && rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check_bit("unexpected rx_valid", 1'b0, rx_valid);
            end else begin
                check_byte("rx_data", exp_q.pop_front(), rx_data);
            end
        end
    end

    task automatic finish_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one-cycle command strobe, then two quiet cycles
    task automatic command(input logic en, input logic dis, input logic rst);
        @(negedge clk_sys);
        receive_enable_cmd = en;
        receive_disable_cmd = dis;
        receiver_reset_cmd = rst;
        @(negedge clk_sys);
        receive_enable_cmd = 1'b0;
        receive_disable_cmd = 1'b0;
        receiver_reset_cmd = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask

    // bounded wait until every noted word has been taken
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 4000) begin
            @(negedge clk_sys);
            n++;
        end
        check_bit("queue empty", 1'b1, exp_q.size() == 0);
    endtask

    task automatic send_exp(input logic [7:0] d);
        exp_q.push_back(d);
        tx.send_char(d);
    endtask

    initial begin
        #(60000 * 8);
        err_count++;
        finish_test();
    end

    initial begin
        logic [7:0] d;
        void'($urandom(32'ha7ae4eaa));
        rstn = 1'b0;
        sample_tick = 1'b0;
        receive_enable_cmd = 1'b0;
        receive_disable_cmd = 1'b0;
        receiver_reset_cmd = 1'b0;
        hold_off = 1'b0;
        err_count = 0;
        tests_run = 0;
        // one reset edge already loads the synchroniser with ones
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        @(negedge clk_sys);
        check_bit("rx_enabled", 1'b0, rx_enabled);
        tx.send_char(8'h3c);
        @(negedge clk_sys);
        check_bit("rx_busy", 1'b0, rx_busy);
        command(1'b1, 1'b0, 1'b0);
        check_bit("rx_enabled", 1'b1, rx_enabled);
        tx.low_pulse(7);
        @(negedge clk_sys);
        check_bit("rx_busy", 1'b0, rx_busy);
        tx.low_pulse(8);
        @(negedge clk_sys);
        check_bit("rx_busy", 1'b1, rx_busy);
        exp_q.push_back(8'hff);
        tx.ticks(160);
        drain();
        // edge patterns then random characters back to back
        send_exp(8'h55);
        send_exp(8'haa);
        for (int i = 0; i < 4; i++) begin
            send_exp(8'($urandom));
        end
        drain();
        // fill the buffer until it refuses
        hold_off = 1'b1;
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            if (i < 5) exp_q.push_back(d);
            tx.send_char(d);
        end
        repeat (8) @(negedge clk_sys);
        check_bit("rx_overrun", 1'b1, rx_overrun);
        hold_off = 1'b0;
        drain();
        // disable mid character completes the character
        d = 8'($urandom);
        exp_q.push_back(d);
        fork
            tx.send_char(d);
            begin
                tx.ticks(60);
                command(1'b0, 1'b1, 1'b0);
                check_bit("rx_enabled", 1'b1, rx_enabled);
            end
        join
        repeat (4) @(negedge clk_sys);
        check_bit("rx_enabled", 1'b0, rx_enabled);
        drain();
        // disable while hunting stops at once; disable beats enable
        command(1'b1, 1'b0, 1'b0);
        command(1'b0, 1'b1, 1'b0);
        check_bit("rx_enabled", 1'b0, rx_enabled);
        command(1'b1, 1'b1, 1'b0);
        check_bit("rx_enabled", 1'b0, rx_enabled);
        tx.send_char(8'h81);
        @(negedge clk_sys);
        check_bit("rx_busy", 1'b0, rx_busy);
        // reset command aborts, character dropped, overrun cleared
        command(1'b1, 1'b0, 1'b0);
        fork
            tx.send_char(8'h7e);
            begin
                tx.ticks(60);
                command(1'b0, 1'b0, 1'b1);
                check_bit("rx_enabled", 1'b0, rx_enabled);
                check_bit("rx_busy", 1'b0, rx_busy);
                check_bit("rx_overrun", 1'b0, rx_overrun);
            end
        join
        command(1'b1, 1'b0, 1'b0);
        send_exp(8'($urandom));
        drain();
        finish_test();
    end
endmodule // urf_rx_bench
